/* File: hdl/ref_switch_pkg.sv */
// Package for the redundant reference clock switch.
// Assumes all control pins are synchronous to mclk.
package ref_switch_pkg;
  // Feedback periods an input may stay at one level before it is failed
  localparam int unsigned STUCK_PERIODS = 1;
  // Initial reference after reset (input 0)
  localparam logic RST_REF = 1'b0;
  // Reset level of the fault flags
  localparam logic RST_FAULT = 1'b0;
  // Reset levels of the divider outputs
  localparam logic RST_TRUE_OUT = 1'b0;
  localparam logic RST_COMP_OUT = 1'b1;
  // Reset level of the init strobe history (inactive high)
  localparam logic RST_INIT_PREV = 1'b1;
  // Reset level of the feedback history; high so release cannot fake a rise
  localparam logic RST_FB_PREV = 1'b1;
endpackage

/* File: hdl/ref_monitor_if.sv */
// Interface carrying one input's fault monitor signals.
// Assumes the monitor and the switch share mclk.
`timescale 1ns/1ps
interface ref_monitor_if;
  logic ref_in;
  logic fb_clk;
  logic clear;
  logic fault;
  modport mon (input ref_in, input fb_clk, input clear, output fault);
  modport ctl (output ref_in, output fb_clk, output clear, input fault);
endinterface

/* File: hdl/ref_fault_monitor.sv */
// Stuck-level detector for one reference input.
// Assumes ref_in and fb_clk are sampled in the mclk domain.
`timescale 1ns/1ps
module ref_fault_monitor
  import ref_switch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  ref_monitor_if.mon mif
);
  logic ref_prev_q;
  logic fb_prev_q;
  logic [1:0] rise_cnt_q;
  logic fault_q;
  logic ref_edge;
  logic fb_rise;

  assign ref_edge = mif.ref_in ^ ref_prev_q;
  assign fb_rise = mif.fb_clk & ~fb_prev_q;
  assign mif.fault = fault_q;

  // Edge history
  always_ff @(posedge mclk) begin
    if (rst) begin
      ref_prev_q <= 1'b0;
      fb_prev_q <= RST_FB_PREV;
    end else begin
      ref_prev_q <= mif.ref_in;
      fb_prev_q <= mif.fb_clk;
    end
  end

  // Count feedback rises without a reference edge; full period needs two
  always_ff @(posedge mclk) begin
    if (rst || mif.clear || ref_edge) begin
      rise_cnt_q <= 2'h0;
    end else if (fb_rise && rise_cnt_q != 2'h3) begin
      rise_cnt_q <= rise_cnt_q + 2'h1;
    end
  end

  // Fault follows the live condition; set beats the init clear, a reference edge beats set
  always_ff @(posedge mclk) begin
    if (rst) begin
      fault_q <= RST_FAULT;
    end else if (!ref_edge && fb_rise && rise_cnt_q >= 2'(STUCK_PERIODS)) begin
      fault_q <= 1'b1;
    end else if (ref_edge || mif.clear) begin
      fault_q <= 1'b0;
    end
  end
endmodule

/* File: hdl/redundant_ref_clock_switch.sv */
// Reference selection, fault flags and divider reset for two redundant inputs.
// Assumes all pins synchronous to mclk; feedback clock is sampled as data.
//
// Operation
// - Exactly one input is the reference.
// - Select pin picks initial input; default 0.
// - Indicator shows active input; starts at input 0 until init fall, override or automatic switch-over.
// - Init falling edge latches initial, clears faults unless one sets in that cycle.
// - Stuck one feedback period sets fault flag.
// - Fault flags track live input condition.
// - Override high forces selected input.
// - Manual select change switches reference, indicator.
// - Override low enables automatic switching.
// - Initial fails, good secondary: switch over.
// - No switch back while secondary good.
// - Secondary fails: return if initial good.
// - Master reset low holds divider outputs reset.
`timescale 1ns/1ps
module redundant_ref_clock_switch
  import ref_switch_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic reference_input_0,
  input wire logic reference_input_1,
  input wire logic feedback_clk,
  input wire logic select_clk,
  input wire logic manual_override,
  input wire logic init_strobe_n,
  input wire logic master_reset_n,
  input wire logic divider_clk,
  output logic active_ref_indicator,
  output logic active_ref_clk,
  output logic input0_fault_flag,
  output logic input1_fault_flag,
  output logic true_clock_outputs,
  output logic complement_clock_outputs
);
  logic init_prev_q;
  logic init_fall;
  logic initial_q;
  logic sel_q;
  logic sel_d;
  logic automatic_ref_switching;
  logic fault0;
  logic fault1;
  logic div_q;

  ref_monitor_if mon0 ();
  ref_monitor_if mon1 ();

  assign mon0.ref_in = reference_input_0;
  assign mon0.fb_clk = feedback_clk;
  assign mon0.clear = init_fall;
  assign mon1.ref_in = reference_input_1;
  assign mon1.fb_clk = feedback_clk;
  assign mon1.clear = init_fall;
  assign fault0 = mon0.fault;
  assign fault1 = mon1.fault;

  ref_fault_monitor u_mon0 (.mclk(mclk), .rst(rst), .mif(mon0));
  ref_fault_monitor u_mon1 (.mclk(mclk), .rst(rst), .mif(mon1));

  // Init strobe falling edge detect
  assign init_fall = init_prev_q & ~init_strobe_n;
  always_ff @(posedge mclk) begin
    if (rst) begin
      init_prev_q <= RST_INIT_PREV;
    end else begin
      init_prev_q <= init_strobe_n;
    end
  end

  // Initial clock register
  always_ff @(posedge mclk) begin
    if (rst) begin
      initial_q <= RST_REF;
    end else if (init_fall) begin
      initial_q <= select_clk;
    end
  end

  assign automatic_ref_switching = ~manual_override;

  // Next reference selection
  always_comb begin
    sel_d = sel_q;
    if (init_fall || manual_override) begin
      sel_d = select_clk;
    end else if (automatic_ref_switching) begin
      if (sel_q == initial_q) begin
        if ((initial_q ? fault1 : fault0) && !(initial_q ? fault0 : fault1)) begin
          sel_d = ~initial_q;
        end
      end else begin
        if ((sel_q ? fault1 : fault0) && !(initial_q ? fault1 : fault0)) begin
          sel_d = initial_q;
        end
      end
    end
  end

  // Selection register: a single bit, so only one input is ever chosen
  always_ff @(posedge mclk) begin
    if (rst) begin
      sel_q <= RST_REF;
    end else begin
      sel_q <= sel_d;
    end
  end

  // Indicator and muxed reference, updated after the selection settles
  always_ff @(posedge mclk) begin
    if (rst) begin
      active_ref_indicator <= RST_REF;
      active_ref_clk <= 1'b0;
    end else begin
      active_ref_indicator <= sel_q;
      active_ref_clk <= sel_q ? reference_input_1 : reference_input_0;
    end
  end

  // Fault flag outputs
  always_ff @(posedge mclk) begin
    if (rst) begin
      input0_fault_flag <= RST_FAULT;
      input1_fault_flag <= RST_FAULT;
    end else begin
      input0_fault_flag <= fault0;
      input1_fault_flag <= fault1;
    end
  end

  // Divider stand-in: toggles on divider_clk, held while master reset low
  always_ff @(posedge mclk) begin
    if (rst || !master_reset_n) begin
      div_q <= RST_TRUE_OUT;
      true_clock_outputs <= RST_TRUE_OUT;
      complement_clock_outputs <= RST_COMP_OUT;
    end else begin
      div_q <= divider_clk ? ~div_q : div_q;
      true_clock_outputs <= div_q;
      complement_clock_outputs <= ~div_q;
    end
  end

  a_manual_follows: assert property (@(posedge mclk) disable iff (rst)
    manual_override |=> sel_q == $past(select_clk)) else $error("manual select not followed");
  a_indicator_lag: assert property (@(posedge mclk) disable iff (rst)
    1'b1 |=> active_ref_indicator == $past(sel_q)) else $error("indicator wrong");
  a_init_clears: assert property (@(posedge mclk) disable iff (rst)
    init_fall && !$rose(feedback_clk) |=> !fault0 && !fault1) else $error("init did not clear faults");
  a_init_latch: assert property (@(posedge mclk) disable iff (rst)
    init_fall |=> initial_q == $past(select_clk)) else $error("initial not latched");
  a_mr_holds: assert property (@(posedge mclk) disable iff (rst)
    !master_reset_n |=> !true_clock_outputs && complement_clock_outputs) else $error("reset outputs");
  a_auto_switch: assert property (@(posedge mclk) disable iff (rst)
    (!manual_override && !init_fall && sel_q == initial_q && (initial_q ? fault1 : fault0)
     && !(initial_q ? fault0 : fault1)) |=> sel_q != initial_q) else $error("no auto switch");
  a_no_back: assert property (@(posedge mclk) disable iff (rst)
    (!manual_override && !init_fall && sel_q != initial_q && !(sel_q ? fault1 : fault0))
    |=> $stable(sel_q)) else $error("needless switch back");
  a_both_bad: assert property (@(posedge mclk) disable iff (rst)
    (!manual_override && !init_fall && fault0 && fault1) |=> $stable(sel_q)) else $error("switched to bad");
  a_return_init: assert property (@(posedge mclk) disable iff (rst)
    (!manual_override && !init_fall && sel_q != initial_q && (sel_q ? fault1 : fault0)
     && !(initial_q ? fault1 : fault0)) |=> sel_q == initial_q) else $error("no return");
endmodule

/* File: verif/board_ref_model.sv */
// Board-side model: two reference clocks, feedback clock and divider enable.
// Assumes the bench sets the stuck controls; all lines change on mclk.
`timescale 1ns/1ps
module board_ref_model (
  input wire logic mclk,
  input wire logic stuck0,
  input wire logic stuck1,
  output logic ref0 = 1'b0,
  output logic ref1 = 1'b1,
  output logic fb_clk = 1'b0,
  output logic div_en = 1'b0
);
  logic [1:0] fb_cnt_q = 2'h0;

  // A stuck input freezes at its present level, like a dead source
  always @(posedge mclk) begin
    ref0 <= stuck0 ? ref0 : ~ref0;
    ref1 <= stuck1 ? ref1 : ~ref1;
    div_en <= ~div_en;
    fb_cnt_q <= fb_cnt_q + 2'h1;
    if (fb_cnt_q == 2'h3) begin
      fb_clk <= ~fb_clk; // Feedback period is eight mclk cycles
    end
  end
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench for the redundant reference switch.
// Assumes the board model supplies clocks; control pins come from here.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
`define WT(c, n) begin k = 0; while (!(c) && k < n) begin @(negedge mclk); k++; end end
module tb_top;
  import ref_switch_pkg::*;
  logic mclk, rst, select_clk, manual_override, init_strobe_n, master_reset_n, stuck0, stuck1;
  logic ref0, ref1, fb_clk, div_en, ind, ref_clk, flag0, flag1, true_out, comp_out;
  int miscompares = 0;
  int tests_run = 0;
  int k;

  board_ref_model i_board (.mclk(mclk), .stuck0(stuck0), .stuck1(stuck1), .ref0(ref0), .ref1(ref1),
    .fb_clk(fb_clk), .div_en(div_en));
  redundant_ref_clock_switch i_dut (.mclk(mclk), .rst(rst), .reference_input_0(ref0),
    .reference_input_1(ref1), .feedback_clk(fb_clk), .select_clk(select_clk),
    .manual_override(manual_override), .init_strobe_n(init_strobe_n), .master_reset_n(master_reset_n),
    .divider_clk(div_en), .active_ref_indicator(ind), .active_ref_clk(ref_clk),
    .input0_fault_flag(flag0), .input1_fault_flag(flag1), .true_clock_outputs(true_out),
    .complement_clock_outputs(comp_out));

  // Prints the counts and the verdict, then ends the run
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #(25 * 4000);
    miscompares++;
    report_and_stop();
  end

  // Main sequence: manual start-up, then automatic switching
  initial begin
    rst = 1'b1; select_clk = 1'b1; manual_override = 1'b1; init_strobe_n = 1'b1;
    master_reset_n = 1'b0; stuck0 = 1'b0; stuck1 = 1'b0;
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    `CHK(ind, 1'b0)
    @(posedge mclk) rst <= 1'b0;
    `WT(ind === 1'b1, 10)
    `CHK(ind, 1'b1)
    `CHK(true_out, 1'b0)
    `CHK(comp_out, 1'b1)
    @(posedge mclk) master_reset_n <= 1'b1;
    `WT(true_out === 1'b1, 10)
    `CHK(comp_out, 1'b0)
    @(posedge mclk) stuck1 <= 1'b1;
    `WT(flag1 === 1'b1, 40)
    `CHK(flag1, 1'b1)
    `CHK(ref_clk, ref1)
    `CHK(ind, 1'b1)
    @(posedge mclk) stuck1 <= 1'b0;
    `WT(flag1 === 1'b0, 10)
    `CHK(flag1, 1'b0)
    @(posedge mclk) select_clk <= 1'b0;
    `WT(ind === 1'b0, 10)
    `CHK(ind, 1'b0)
    @(posedge mclk) manual_override <= 1'b0;
    @(posedge mclk) init_strobe_n <= 1'b0;
    @(posedge mclk) init_strobe_n <= 1'b1;
    @(posedge mclk) stuck0 <= 1'b1;
    `WT(ind === 1'b1, 40)
    `CHK(ind, 1'b1)
    `CHK(flag0, 1'b1)
    `CHK(ref_clk, ~ref1)
    @(negedge mclk);
    `CHK(ref_clk, ~ref1)
    @(posedge mclk) stuck0 <= 1'b0;
    `WT(flag0 === 1'b0, 10)
    repeat (20) @(negedge mclk);
    `CHK(ind, 1'b1)
    @(posedge mclk) stuck1 <= 1'b1;
    `WT(ind === 1'b0, 40)
    `CHK(ind, 1'b0)
    @(posedge mclk) stuck0 <= 1'b1;
    `WT(flag0 === 1'b1, 40)
    repeat (20) @(negedge mclk);
    `CHK(ind, 1'b0)
    // Keep the init fall clear of a feedback rise, where a fresh fault would win
    @(negedge fb_clk);
    @(posedge mclk) init_strobe_n <= 1'b0;
    `WT(flag0 === 1'b0 && flag1 === 1'b0, 4)
    `CHK({flag0, flag1}, 2'h0)
    // Mid-run reset, then automatic start-up with select high
    @(posedge mclk) rst <= 1'b1;
    init_strobe_n <= 1'b1;
    select_clk <= 1'b1;
    stuck0 <= 1'b0;
    stuck1 <= 1'b0;
    repeat (3) @(negedge mclk);
    `CHK({ind, flag0, flag1}, 3'h0)
    @(posedge mclk) rst <= 1'b0;
    repeat (3) @(negedge mclk);
    `CHK(ind, 1'b0)
    @(posedge mclk) init_strobe_n <= 1'b0;
    `WT(ind === 1'b1, 10)
    `CHK(ind, 1'b1)
    `CHK({flag0, flag1}, 2'h0)
    report_and_stop();
  end
endmodule
